// [bench/ahb_cpu_model.sv]
`default_nettype none
module ahb_cpu_model (
  // Clock and answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung = 1'b0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end
  // Answer read at the rising edge, before the slave's flops update
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {18'h0_0000, a, 2'b00};
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) hung = 1'b1;
    htrans <= 2'b00;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    r = hrdata;
    if (hready !== 1'b1) hung = 1'b1;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`include "timers_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, r, h;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hsel, hwrite, hreadyout, hresp, irq, dss, hls, p0d;
  int          err_total = 0;
  int          compares = 0;
  always #25 hclk = ~hclk;
  // Ten-cycle tick keeps a full second near 2560 cycles
  clock_and_stopwatch_timers #(.CLK_HZ(2560)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .display_static_select(dss),
    .heavy_load_select(hls), .port0_direction(p0d));
  ahb_cpu_model master_u (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    master_u.xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    master_u.xfer(1'b1, a, d, h);
  endtask
  task automatic irq_is(input logic v);
    @(negedge hclk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, v});
  endtask
  task automatic s_reset();
    logic [11:0] idx [9] = '{`IDX_CLOCK_COUNTER_NIBBLE, `IDX_STOPWATCH_HUNDREDTHS, `IDX_STOPWATCH_TENTHS,
      `IDX_STOPWATCH_MASK, `IDX_CLOCK_MASK, `IDX_CLOCK_FLAGS, `IDX_STOPWATCH_FLAGS, `IDX_TIMER_CONTROL, 12'h073};
    foreach (idx[i]) rd(idx[i], 32'h0000_0000);
    chk({28'h000_0000, irq, dss, hls, p0d}, 32'h0000_0000);
  endtask
  task automatic s_clock();
    wr(`IDX_TIMER_CONTROL, 32'h0000_0008);
    master_u.xfer(1'b0, `IDX_CLOCK_FLAGS, 32'h0000_0000, r);
    rd(`IDX_CLOCK_FLAGS, 32'h0000_0000);
    repeat (100) @(posedge hclk);
    irq_is(1'b0);
    rd(`IDX_CLOCK_FLAGS, 32'h0000_0001);
    rd(`IDX_CLOCK_COUNTER_NIBBLE, 32'h0000_0001);
    wr(`IDX_CLOCK_COUNTER_NIBBLE, 32'h0000_000F);
    repeat (60) @(posedge hclk);
    rd(`IDX_CLOCK_COUNTER_NIBBLE, 32'h0000_0002);
    wr(`IDX_CLOCK_MASK, 32'h0000_000F);
    rd(`IDX_CLOCK_MASK, 32'h0000_000F);
    repeat (45) @(posedge hclk);
    irq_is(1'b1);
    wr(`IDX_TIMER_CONTROL, 32'h0000_0008);
    master_u.xfer(1'b0, `IDX_CLOCK_FLAGS, 32'h0000_0000, r);
    @(posedge hclk);
    irq_is(1'b0);
    repeat (1300) @(posedge hclk);
    rd(`IDX_CLOCK_FLAGS, 32'h0000_0007);
    wr(`IDX_CLOCK_MASK, 32'h0000_0000);
  endtask
  task automatic s_stopwatch();
    wr(`IDX_TIMER_CONTROL, 32'h0000_0007);
    rd(`IDX_TIMER_CONTROL, 32'h0000_0005);
    chk({31'h0000_0000, p0d}, 32'h0000_0001);
    repeat (2440) @(posedge hclk);
    wr(`IDX_TIMER_CONTROL, 32'h0000_0000);
    rd(`IDX_STOPWATCH_TENTHS, 32'h0000_0009);
    master_u.xfer(1'b0, `IDX_STOPWATCH_HUNDREDTHS, 32'h0000_0000, h);
    repeat (100) @(posedge hclk);
    rd(`IDX_STOPWATCH_HUNDREDTHS, h);
    wr(`IDX_TIMER_CONTROL, 32'h0000_0004);
    master_u.xfer(1'b0, `IDX_STOPWATCH_FLAGS, 32'h0000_0000, r);
    repeat (200) @(posedge hclk);
    irq_is(1'b0);
    wr(`IDX_STOPWATCH_MASK, 32'h0000_000F);
    irq_is(1'b1);
    rd(`IDX_STOPWATCH_MASK, 32'h0000_000B);
    chk({31'h0000_0000, hls}, 32'h0000_0001);
    rd(`IDX_STOPWATCH_FLAGS, 32'h0000_0003);
    rd(`IDX_STOPWATCH_TENTHS, 32'h0000_0000);
    wr(`IDX_STOPWATCH_MASK, 32'h0000_0000);
    wr(`IDX_TIMER_CONTROL, 32'h0000_0006);
    repeat (53) @(posedge hclk);
    rd(`IDX_STOPWATCH_HUNDREDTHS, 32'h0000_0002);
    wr(`IDX_TIMER_CONTROL, 32'h0000_0002);
    rd(`IDX_STOPWATCH_HUNDREDTHS, 32'h0000_0000);
    repeat (60) @(posedge hclk);
    rd(`IDX_STOPWATCH_HUNDREDTHS, 32'h0000_0000);
    rd(`IDX_TIMER_CONTROL, 32'h0000_0000);
  endtask
  task automatic summarize();
    if (master_u.hung) err_total++;
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    s_reset();
    s_clock();
    s_stopwatch();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire

// [bench/timers_chk.sv]
`default_nettype none
module timers_chk (
  // Bus and outputs
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        display_static_select
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        rd_q;
  logic        wr_q;
  logic [11:0] a_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Data phase tracking; the design answers with zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q  <= 12'h000;
    end else begin
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      wr_q <= hsel && hready && htrans[1] && hwrite;
      a_q  <= haddr[11:0];
    end
  end
  ready_high_a: assert property (hreadyout) else $error("wait state");
  resp_okay_a: assert property (!hresp) else $error("error response");
  upper_zero_a: assert property (rd_q |-> hrdata[31:4] == 28'h000_0000) else $error("upper bits set");
  flag_top_a: assert property (rd_q && a_q == 12'h1E4 |-> !hrdata[3]) else $error("flag D3 set");
  strobe_zero_a: assert property (rd_q && a_q == 12'h1F8 |-> !hrdata[3] && !hrdata[1]) else $error("strobe read");
  swmask_d2_a: assert property (rd_q && a_q == 12'h1D8 |-> !hrdata[2]) else $error("mask D2 set");
  bcd_digit_a: assert property (rd_q && a_q inside {12'h1C4, 12'h1C8} |-> hrdata[3:0] <= 4'h9) else $error("not BCD");
  static_wr_a: assert property (wr_q && a_q == 12'h1E0 |=> display_static_select == $past(hwdata[3])) else $error("bit lost");
endmodule
bind clock_and_stopwatch_timers timers_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .display_static_select);
`default_nettype wire

// [hw/clock_and_stopwatch_timers.sv]
// Design decision made here: the AHB-Lite register port.
`include "timers_regs.svh"
`default_nettype none
// Notes on behaviour
// - Clock counter is 7-bit, free-running, advanced by the 256 Hz tick.
// - Upper four counter bits read at 070H, read-only, reset to zero.
// - Falling edge of 32, 8, 2 Hz taps sets the matching flag.
// - Clock flags set regardless of mask bits.
// - Mask bits CLOCK_MASK_AND_DRIVE_SELECT D0..D2 enable 32, 8, 2 Hz interrupts; reset zero.
// - Clock flags 079H clear on read; writes ignored; D3 reads zero.
// - Writing one to TIMER_CONTROL_STROBES D3 clears counter; counting resumes; reads zero.
// - All rates scale with the oscillator; tick divider set by parameter.
// - Counter clear may leave a flag set; software reads flags afterwards.
// - Stopwatch: BCD hundredths at 071H, tenths at 072H, read-only.
// - Hundredths advance every 2 or 3 ticks; decade is 25 or 26 ticks.
// - Tenths count decades; 25/26 periods in 4:6 ratio give one second.
// - Hundredths 9 to 0 sets 10 Hz flag; tenths 9 to 0 sets 1 Hz flag.
// - Stopwatch flags set regardless of mask bits.
// - Masks at STOPWATCH_MASK_AND_LOAD_MODE: D0 10 Hz, D1 1 Hz; D2 reads zero.
// - Run bit TIMER_CONTROL_STROBES D2 starts or stops stopwatch; digits hold when stopped.
// - Writing one to TIMER_CONTROL_STROBES D1 clears both digits; run state follows D2 of the same write.
// - Stopwatch flags 07AH D0, D1 clear on read; writes ignored.
module clock_and_stopwatch_timers #(
  parameter int OSC_HZ  = `OSC_HZ,
  parameter int CLK_HZ  = `CLK_HZ,
  parameter int TICK_HZ = `TICK_HZ
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // Interrupt request and side controls
  output var  logic        irq,
  output var  logic        display_static_select,
  output var  logic        heavy_load_select,
  output var  logic        port0_direction
);
  import timers_pkg::*;

  // Tick period in hclk cycles; the 256 Hz tap follows the oscillator rate
  // 64-bit so the product cannot overflow at the full clock rate
  localparam longint TICK_CYCLES_RAW = longint'(CLK_HZ) / TICK_HZ * `OSC_HZ / OSC_HZ;
  localparam longint TICK_CYCLES     = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  state_type s_q;
  state_type s_d;

  function automatic logic [3:0] bcd_inc(input logic [3:0] v);
    bcd_inc = (v == `DIGIT_LAST) ? `DIGIT_ZERO : 4'(v + 4'h1);
  endfunction

  function automatic logic [31:0] nib(input logic [3:0] v);
    nib = {28'h000_0000, v};
  endfunction

  logic [6:0] cnt_next;
  logic       sw_step;
  logic       wrap_l;
  logic       wrap_h;
  logic [1:0] sub_last;
  logic [2:0] clk_set;
  logic [1:0] sw_set;
  logic       rd_clk_flags;
  logic       rd_sw_flags;
  logic [3:0] wnib;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    rd_clk_flags = 1'b0;
    rd_sw_flags = 1'b0;
    wnib = hwdata[3:0];

    // Base tick divider
    if (s_q.div >= TICK_LAST) begin
      s_d.div = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 32'h0000_0001;
    end

    // Clock counter
    cnt_next = s_q.tick ? 7'(s_q.counter + 7'h01) : s_q.counter;
    clk_set[0] = s_q.counter[`TAP_32HZ] & ~cnt_next[`TAP_32HZ];
    clk_set[1] = s_q.counter[`TAP_8HZ] & ~cnt_next[`TAP_8HZ];
    clk_set[2] = s_q.counter[`TAP_2HZ] & ~cnt_next[`TAP_2HZ];
    s_d.counter = cnt_next;

    // Stopwatch: three ticks after odd digits, one more after 8 in decades 4..9
    // Decades 0..3 take 25 ticks, 4..9 take 26 (4:6, 256 ticks a second)
    sub_last = (s_q.hundredths[0] == 1'b1 ||
                (s_q.decade >= 4'h4 && s_q.hundredths == 4'h8)) ? 2'd2 : 2'd1;
    sw_step = 1'b0;
    wrap_l = 1'b0;
    wrap_h = 1'b0;
    if (s_q.sw_run && s_q.tick) begin
      if (s_q.sub >= sub_last) begin
        s_d.sub = 2'd0;
        sw_step = 1'b1;
      end else begin
        s_d.sub = 2'(s_q.sub + 2'd1);
      end
    end
    if (sw_step) begin
      s_d.hundredths = bcd_inc(s_q.hundredths);
      wrap_l = (s_q.hundredths == `DIGIT_LAST);
      if (wrap_l) begin
        s_d.tenths = bcd_inc(s_q.tenths);
        s_d.decade = bcd_inc(s_q.decade);
        wrap_h = (s_q.tenths == `DIGIT_LAST);
      end
    end
    sw_set = {wrap_h, wrap_l};

    // Bus
    s_d.hreadyout = 1'b1;
    s_d.phase = BUS_IDLE;
    case (s_q.phase)
      BUS_WRITE: begin
        case (s_q.index)
          10'(`IDX_STOPWATCH_MASK): begin
            s_d.sw_irq.enable = wnib[1:0];
            s_d.heavy_load = wnib[`BIT_HEAVY_LOAD];
          end
          10'(`IDX_CLOCK_MASK): begin
            s_d.clk_irq.enable = wnib[2:0];
            s_d.display_static = wnib[`BIT_DISPLAY_STATIC];
          end
          10'(`IDX_TIMER_CONTROL): begin
            s_d.sw_run = wnib[`BIT_SW_RUN];
            s_d.port0_dir = wnib[`BIT_PORT0_DIR];
            if (wnib[`BIT_CLOCK_CLEAR]) begin
              s_d.counter = 7'h00;
              clk_set = 3'b000;
            end
            if (wnib[`BIT_SW_CLEAR]) begin
              s_d.hundredths = `DIGIT_ZERO;
              s_d.tenths = `DIGIT_ZERO;
              s_d.decade = `DIGIT_ZERO;
              s_d.sub = 2'd0;
              sw_set = 2'b00;
            end
          end
          default: begin
          end
        endcase
      end
      default: begin
      end
    endcase

    // Read data registered at address phase
    s_d.hrdata = 32'h0000_0000;
    if (hsel && hready && htrans[1]) begin
      s_d.index = 10'(haddr[11:2]);
      s_d.phase = hwrite ? BUS_WRITE : BUS_READ;
      if (!hwrite) begin
        case (10'(haddr[11:2]))
          10'(`IDX_CLOCK_COUNTER_NIBBLE): s_d.hrdata = nib(s_q.counter[6:3]);
          10'(`IDX_STOPWATCH_HUNDREDTHS): s_d.hrdata = nib(s_q.hundredths);
          10'(`IDX_STOPWATCH_TENTHS):     s_d.hrdata = nib(s_q.tenths);
          10'(`IDX_STOPWATCH_MASK):
            s_d.hrdata = nib({s_q.heavy_load, 1'b0, s_q.sw_irq.enable});
          10'(`IDX_CLOCK_MASK):
            s_d.hrdata = nib({s_q.display_static, s_q.clk_irq.enable});
          10'(`IDX_CLOCK_FLAGS): begin
            s_d.hrdata = nib({1'b0, s_q.clk_irq.flags});
            rd_clk_flags = 1'b1;
          end
          10'(`IDX_STOPWATCH_FLAGS): begin
            s_d.hrdata = nib({2'b00, s_q.sw_irq.flags});
            rd_sw_flags = 1'b1;
          end
          10'(`IDX_TIMER_CONTROL):
            s_d.hrdata = nib({1'b0, s_q.sw_run, 1'b0, s_q.port0_dir});
          default: s_d.hrdata = 32'h0000_0000;
        endcase
      end
    end

    // Flags: set wins over clear-on-read
    s_d.clk_irq.flags = (rd_clk_flags ? 3'b000 : s_q.clk_irq.flags) | clk_set;
    s_d.sw_irq.flags = (rd_sw_flags ? 2'b00 : s_q.sw_irq.flags) | sw_set;

    s_d.irq = |(s_d.clk_irq.flags & s_d.clk_irq.enable) |
              |(s_d.sw_irq.flags & s_d.sw_irq.enable);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.hreadyout <= 1'b1;
      s_q.phase <= BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata                = s_q.hrdata;
  assign hreadyout             = s_q.hreadyout;
  assign hresp                 = 1'b0;
  assign irq                   = s_q.irq;
  assign display_static_select = s_q.display_static;
  assign heavy_load_select     = s_q.heavy_load;
  assign port0_direction       = s_q.port0_dir;
endmodule
`default_nettype wire

// [hw/timers_pkg.sv]
`default_nettype none
package timers_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_phase_type;

  typedef struct packed {
    logic [2:0] flags;
    logic [2:0] enable;
  } clock_irq_type;

  typedef struct packed {
    logic [1:0] flags;
    logic [1:0] enable;
  } sw_irq_type;

  typedef struct packed {
    bus_phase_type phase;
    logic [9:0]    index;
    logic          hreadyout;
    logic [31:0]   hrdata;
    logic [31:0]   div;
    logic          tick;
    logic [6:0]    counter;
    clock_irq_type clk_irq;
    logic [3:0]    hundredths;
    logic [3:0]    tenths;
    logic [1:0]    sub;
    logic [3:0]    decade;
    logic          sw_run;
    sw_irq_type    sw_irq;
    logic          display_static;
    logic          heavy_load;
    logic          port0_dir;
    logic          irq;
  } state_type;
endpackage
`default_nettype wire

// [hw/timers_regs.svh]
`ifndef TIMERS_REGS_SVH
`define TIMERS_REGS_SVH
// Register word indices (printed offsets are not all word aligned: byte address is index * 4)
`define IDX_CLOCK_COUNTER_NIBBLE 12'h070
`define IDX_STOPWATCH_HUNDREDTHS 12'h071
`define IDX_STOPWATCH_TENTHS     12'h072
`define IDX_STOPWATCH_MASK       12'h076
`define IDX_CLOCK_MASK           12'h078
`define IDX_CLOCK_FLAGS          12'h079
`define IDX_STOPWATCH_FLAGS      12'h07A
`define IDX_TIMER_CONTROL        12'h07E
// Field positions
`define BIT_CLOCK_CLEAR          3
`define BIT_SW_RUN               2
`define BIT_SW_CLEAR             1
`define BIT_PORT0_DIR            0
`define BIT_DISPLAY_STATIC       3
`define BIT_HEAVY_LOAD           3
// Counter taps: bit 0 = 128 Hz, bit 2 = 32 Hz, bit 4 = 8 Hz, top bit 6 = 2 Hz
`define TAP_32HZ                 2
`define TAP_8HZ                  4
`define TAP_2HZ                  6
`define DIGIT_LAST               4'h9
`define DIGIT_ZERO               4'h0
// Oscillator and tick figures
`define OSC_HZ                   32768
`define TICK_HZ                  256
`define CLK_HZ                   20000000
`define NIBBLE_RESET             4'h0
`endif
